// file: hdl/scir_defs.svh
// Offsets, field positions, reset values and timing values in nanoseconds of the setup registers
`ifndef SCIR_DEFS_SVH
`define SCIR_DEFS_SVH

// ----------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------
`define SCIR_OFS_SETUP 15'h0000
`define SCIR_OFS_POWER 15'h0002
`define SCIR_OFS_CLASS 15'h0003
`define SCIR_OFS_FAMLO 15'h0004
`define SCIR_OFS_FAMHI 15'h0005
`define SCIR_OFS_HOLD 15'h0010

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define SCIR_BIT_SRST 7
`define SCIR_BIT_ASCEND 5
`define SCIR_BIT_RDOUT 4
`define SCIR_BIT_HOLD 0

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define SCIR_RST_SETUP 8'h30
`define SCIR_RST_POWER 8'h00
`define SCIR_RST_HOLD 8'h00

// ----------------------------------------------------------------------
// Timing: soft reset hold time and clock period
// ----------------------------------------------------------------------
`define SCIR_SRST_NS 750
`define SCIR_CLK_NS 40

`endif

// file: hdl/scir_pkg.sv
// Types shared by the setup register block
package scir_pkg;

   // Power state encodings
   typedef enum logic [1:0]
   {
      SCIR_PWR_NORMAL = 2'h0,
      SCIR_PWR_RSVD1 = 2'h1,
      SCIR_PWR_RSVD2 = 2'h2,
      SCIR_PWR_DOWN = 2'h3
   } scir_pwr_t;

   // Serial frame states
   typedef enum logic [1:0]
   {
      SCIR_ST_CMD,
      SCIR_ST_DATA,
      SCIR_ST_BUSY
   } scir_state_t;

endpackage : scir_pkg

// file: hdl/serial_config_id_regs.sv
// Serial control port slave with setup, power and identification registers
//
// Function
// - Soft reset bit seven resets whole chip
// - Soft reset bit clears itself afterwards
// - Read output flag bit four reads one
// - Direction bit five: zero down, one up
// - Power field: zero normal, three down
// - Device class field fixed read-only code
// - Family identification sixteen-bit fixed read-only
// - Setup register resets to 0x30
// - Address freeze keeps streaming address constant
`timescale 1ns/10ps
`include "scir_defs.svh"

module serial_config_id_regs
#(
   parameter logic [3:0] CLASS_CODE = 4'ha,      // Arbitrary value
   parameter logic [15:0] FAMILY_CODE = 16'h5a5a // Arbitrary value
)
(
   input wire logic sys_clk,       // System clock, 25 MHz
   input wire logic reset_n,       // Asynchronous reset, active low
   input wire logic spiCsN,        // Chip select pin, active low
   input wire logic spiSclk,       // Serial clock pin
   input wire logic spiSdi,        // Serial data in pin
   output logic spiSdo,            // Serial data out pin, always driven
   output logic chipResetN,        // Chip-wide reset, active low
   output logic [1:0] powerState,  // Selected power state
   output logic powerDown          // Lowest power state selected
);

   // ----------------------------------------------------------------------
   // Derived timing
   // ----------------------------------------------------------------------
   localparam int SRST_CYC = (`SCIR_SRST_NS + `SCIR_CLK_NS - 1) / `SCIR_CLK_NS;

   // ----------------------------------------------------------------------
   // Reset release and pin synchronisers
   // ----------------------------------------------------------------------
   logic [1:0] rstSync_ff;      // Reset release chain
   logic rstN;                  // Released reset
   logic [2:0] pinA_ff;         // First stage of pins
   logic [2:0] pinB_ff;         // Second stage of pins
   logic sclkOld_ff;            // Previous serial clock level

   // Reset release through two flip-flops
   always_ff @(posedge sys_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         rstSync_ff <= 2'h0;
      end
      else
      begin
         rstSync_ff <= {rstSync_ff[0], 1'b1};
      end
   end
   assign rstN = rstSync_ff[1];

   // Pins pass two flip-flops
   always_ff @(posedge sys_clk or negedge rstN)
   begin
      if (!rstN)
      begin
         pinA_ff <= 3'h1;
         pinB_ff <= 3'h1;
         sclkOld_ff <= 1'b0;
      end
      else
      begin
         pinA_ff <= {spiSdi, spiSclk, spiCsN};
         pinB_ff <= pinA_ff;
         sclkOld_ff <= pinB_ff[1];
      end
   end

   logic csN;                   // Synchronised chip select
   logic sdi;                   // Synchronised data in
   logic rise;                  // Serial clock rising edge
   logic fall;                  // Serial clock falling edge
   assign csN = pinB_ff[0];
   assign sdi = pinB_ff[2];
   assign rise = pinB_ff[1] & ~sclkOld_ff;
   assign fall = ~pinB_ff[1] & sclkOld_ff;

   // ----------------------------------------------------------------------
   // Frame and register state
   // ----------------------------------------------------------------------
   scir_pkg::scir_state_t state_ff, nxt_state_ff;   // Frame state
   logic [4:0] bitCnt_ff, nxt_bitCnt_ff;            // Bit position in word
   logic [15:0] shift_ff, nxt_shift_ff;             // Incoming shift register
   logic [14:0] addr_ff, nxt_addr_ff;               // Current register address
   logic rd_ff, nxt_rd_ff;                          // Frame is a read
   logic [7:0] outSh_ff, nxt_outSh_ff;              // Outgoing byte
   logic sdo_ff, nxt_sdo_ff;                        // Data out level
   logic [7:0] setup_ff, nxt_setup_ff;              // Interface setup register
   logic [7:0] power_ff, nxt_power_ff;              // Power state register
   logic [7:0] classHi_ff, nxt_classHi_ff;          // Writable upper class bits
   logic [7:0] hold_ff, nxt_hold_ff;                // Address freeze register
   logic [9:0] srstCnt_ff, nxt_srstCnt_ff;          // Soft reset timer

   // Read mux over the register map
   function automatic logic [7:0] readReg(input logic [14:0] a, input logic [7:0] su,
                                          input logic [7:0] pw, input logic [7:0] ch,
                                          input logic [7:0] hd);
      logic [7:0] v;
      v = 8'h00;
      case (a)
         `SCIR_OFS_SETUP: v = su | (8'h01 << `SCIR_BIT_RDOUT);
         `SCIR_OFS_POWER: v = pw;
         `SCIR_OFS_CLASS: v = {ch[7:4], CLASS_CODE};
         `SCIR_OFS_FAMLO: v = FAMILY_CODE[7:0];
         `SCIR_OFS_FAMHI: v = FAMILY_CODE[15:8];
         `SCIR_OFS_HOLD: v = hd;
         default: v = 8'h00;
      endcase
      return v;
   endfunction : readReg

   // Next address during streaming
   function automatic logic [14:0] stepAddr(input logic [14:0] a, input logic [7:0] su,
                                            input logic [7:0] hd);
      logic [14:0] n;
      n = a;
      if (hd[`SCIR_BIT_HOLD])
      begin
         n = a;
      end
      else if (su[`SCIR_BIT_ASCEND])
      begin
         n = a + 15'h0001;
      end
      else
      begin
         n = a - 15'h0001;
      end
      return n;
   endfunction : stepAddr

   // Next state of frame decoder and registers
   always_comb
   begin
      nxt_state_ff = state_ff;
      nxt_bitCnt_ff = bitCnt_ff;
      nxt_shift_ff = shift_ff;
      nxt_addr_ff = addr_ff;
      nxt_rd_ff = rd_ff;
      nxt_outSh_ff = outSh_ff;
      nxt_sdo_ff = sdo_ff;
      nxt_setup_ff = setup_ff;
      nxt_power_ff = power_ff;
      nxt_classHi_ff = classHi_ff;
      nxt_hold_ff = hold_ff;
      nxt_srstCnt_ff = srstCnt_ff;
      case (state_ff)
         scir_pkg::SCIR_ST_BUSY:
         begin
            // Chip held in reset; serial traffic ignored, host must wait
            if (srstCnt_ff == 10'h000)
            begin
               nxt_state_ff = scir_pkg::SCIR_ST_CMD;
            end
            else
            begin
               nxt_srstCnt_ff = srstCnt_ff - 10'h001;
            end
         end
         default:
         begin
            if (csN)
            begin
               // Frame ends: back to command phase, read line parked low
               nxt_state_ff = scir_pkg::SCIR_ST_CMD;
               nxt_bitCnt_ff = 5'h00;
               nxt_sdo_ff = 1'b0;
            end
            else if (rise)
            begin
               nxt_shift_ff = {shift_ff[14:0], sdi};
               nxt_bitCnt_ff = bitCnt_ff + 5'h01;
               if (state_ff == scir_pkg::SCIR_ST_CMD && bitCnt_ff == 5'h0f)
               begin
                  // Command word: read flag then address
                  nxt_rd_ff = shift_ff[14];
                  nxt_addr_ff = {shift_ff[13:0], sdi};
                  nxt_outSh_ff = readReg({shift_ff[13:0], sdi}, setup_ff, power_ff,
                                         classHi_ff, hold_ff);
                  nxt_bitCnt_ff = 5'h00;
                  nxt_state_ff = scir_pkg::SCIR_ST_DATA;
               end
               else if (state_ff == scir_pkg::SCIR_ST_DATA && bitCnt_ff == 5'h07)
               begin
                  nxt_bitCnt_ff = 5'h00;
                  nxt_addr_ff = stepAddr(addr_ff, setup_ff, hold_ff);
                  nxt_outSh_ff = readReg(stepAddr(addr_ff, setup_ff, hold_ff), setup_ff,
                                         power_ff, classHi_ff, hold_ff);
                  if (!rd_ff)
                  begin
                     case (addr_ff)
                        `SCIR_OFS_SETUP:
                        begin
                           nxt_setup_ff = {shift_ff[6:0], sdi};
                           nxt_setup_ff[`SCIR_BIT_RDOUT] = 1'b1;
                           if (sdi == 1'b0 && shift_ff[6])
                           begin
                              // Soft reset: whole chip for the hold time
                              nxt_setup_ff = `SCIR_RST_SETUP;
                              nxt_power_ff = `SCIR_RST_POWER;
                              nxt_classHi_ff = 8'h00;
                              nxt_hold_ff = `SCIR_RST_HOLD;
                              nxt_srstCnt_ff = 10'(SRST_CYC - 1);
                              nxt_state_ff = scir_pkg::SCIR_ST_BUSY;
                           end
                           else if (shift_ff[6])
                           begin
                              // Soft reset with bit zero set as well
                              nxt_setup_ff = `SCIR_RST_SETUP;
                              nxt_power_ff = `SCIR_RST_POWER;
                              nxt_classHi_ff = 8'h00;
                              nxt_hold_ff = `SCIR_RST_HOLD;
                              nxt_srstCnt_ff = 10'(SRST_CYC - 1);
                              nxt_state_ff = scir_pkg::SCIR_ST_BUSY;
                           end
                        end
                        `SCIR_OFS_POWER: nxt_power_ff = {shift_ff[6:0], sdi};
                        `SCIR_OFS_CLASS: nxt_classHi_ff = {shift_ff[6:3], 4'h0};
                        `SCIR_OFS_HOLD: nxt_hold_ff = {shift_ff[6:0], sdi};
                        default: nxt_hold_ff = hold_ff;
                     endcase
                  end
               end
            end
            else if (fall && state_ff == scir_pkg::SCIR_ST_DATA)
            begin
               // Read data leaves on the dedicated output, MSB first
               nxt_sdo_ff = outSh_ff[7];
               nxt_outSh_ff = {outSh_ff[6:0], 1'b0};
            end
         end
      endcase
   end

   // Register the frame and register state
   always_ff @(posedge sys_clk or negedge rstN)
   begin
      if (!rstN)
      begin
         state_ff <= scir_pkg::SCIR_ST_CMD;
         bitCnt_ff <= 5'h00;
         shift_ff <= 16'h0000;
         addr_ff <= 15'h0000;
         rd_ff <= 1'b0;
         outSh_ff <= 8'h00;
         sdo_ff <= 1'b0;
         setup_ff <= `SCIR_RST_SETUP;
         power_ff <= `SCIR_RST_POWER;
         classHi_ff <= 8'h00;
         hold_ff <= `SCIR_RST_HOLD;
         srstCnt_ff <= 10'h000;
      end
      else
      begin
         state_ff <= nxt_state_ff;
         bitCnt_ff <= nxt_bitCnt_ff;
         shift_ff <= nxt_shift_ff;
         addr_ff <= nxt_addr_ff;
         rd_ff <= nxt_rd_ff;
         outSh_ff <= nxt_outSh_ff;
         sdo_ff <= nxt_sdo_ff;
         setup_ff <= nxt_setup_ff;
         power_ff <= nxt_power_ff;
         classHi_ff <= nxt_classHi_ff;
         hold_ff <= nxt_hold_ff;
         srstCnt_ff <= nxt_srstCnt_ff;
      end
   end

   // ----------------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------------
   assign spiSdo = sdo_ff;
   assign chipResetN = rstN & (state_ff != scir_pkg::SCIR_ST_BUSY);
   assign powerState = power_ff[1:0];
   assign powerDown = (power_ff[1:0] == scir_pkg::SCIR_PWR_DOWN);

endmodule : serial_config_id_regs

// file: test/scir_regs_chk_props.sv
// Port checker for the setup and identification register block
`timescale 1ns/10ps
module scir_regs_chk
(
   input wire logic sys_clk,
   input wire logic reset_n,
   input wire logic spiCsN,
   input wire logic spiSclk,
   input wire logic spiSdi,
   input wire logic spiSdo,
   input wire logic chipResetN,
   input wire logic [1:0] powerState,
   input wire logic powerDown
);
   // -----------------------------------------------------------------
   // Helper: length of each chip reset pulse
   // -----------------------------------------------------------------
   logic [7:0] lowCnt_ff; // Cycles seen with chip reset low
   logic [7:0] nxt_lowCnt;
   // Count while low, clear while high
   always_comb nxt_lowCnt = chipResetN ? 8'h00 : lowCnt_ff + 8'h01;
   // Register the count
   always_ff @(posedge sys_clk or negedge reset_n)
      if (!reset_n) lowCnt_ff <= 8'h00;
      else lowCnt_ff <= nxt_lowCnt;
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!reset_n);
   // -----------------------------------------------------------------
   // Properties
   // -----------------------------------------------------------------
   property p_pdn; powerDown == (powerState == 2'h3); endproperty
   a_pdn: assert property (p_pdn) else $error("power down flag wrong");
   property p_rstPwr; !chipResetN |-> powerState == 2'h0 && !powerDown; endproperty
   a_rstPwr: assert property (p_rstPwr) else $error("power not cleared");
   property p_hold; $rose(chipResetN) |-> lowCnt_ff <= 8'h05 ||
      (lowCnt_ff >= 8'h13 && lowCnt_ff <= 8'h16); endproperty
   a_hold: assert property (p_hold) else $error("soft reset hold length wrong");
   property p_idle; spiCsN [*6] |-> spiSdo == 1'b0; endproperty
   a_idle: assert property (p_idle) else $error("read line not low when idle");
   property p_sdoEdge; $changed(spiSdo) && !spiCsN |-> !spiSclk; endproperty
   a_sdoEdge: assert property (p_sdoEdge) else $error("read line moved on high clock");
   property p_pwrSrc; $changed(powerState) |-> !spiCsN || !chipResetN; endproperty
   a_pwrSrc: assert property (p_pwrSrc) else $error("power moved outside frame");
   property p_srcFrame; $fell(chipResetN) |-> !spiCsN; endproperty
   a_srcFrame: assert property (p_srcFrame) else $error("soft reset outside frame");
   property p_rstSdo; !chipResetN |-> spiSdo == 1'b0; endproperty
   a_rstSdo: assert property (p_rstSdo) else $error("read line driven in reset");
   // Main scenarios reached
   c_srst: cover property ($fell(chipResetN));
   c_down: cover property ($rose(powerDown));
   c_sdo: cover property ($rose(spiSdo));
endmodule : scir_regs_chk

// file: test/scir_spi_host.sv
// Serial host model: slow mode-0 frames with command, address and data
`timescale 1ns/10ps
module scir_spi_host
(
   input wire logic sys_clk,
   output logic spiCsN,
   output logic spiSclk,
   output logic spiSdi,
   input wire logic spiSdo
);
   localparam int HALF = 8; // System cycles per serial clock half period
   // Idle: deselected, clock parked low
   initial
   begin
      spiCsN = 1'b1;
      spiSclk = 1'b0;
      spiSdi = 1'b0;
   end
   // Wait n edges then step just past the edge
   task automatic wt(input int n);
      repeat (n) @(posedge sys_clk);
      #1;
   endtask : wt
   // One bit: data set while clock low, read bit taken before the rise
   task automatic bitx(input logic b, output logic r);
      spiSdi = b;
      wt(HALF);
      r = spiSdo;
      spiSclk = 1'b1;
      wt(HALF);
      spiSclk = 1'b0;
   endtask : bitx
   // Whole frame; data is left aligned, read bytes come back right aligned
   task automatic frame(input logic rd, input logic [14:0] adr, input logic [31:0] wr,
                        input int n, output logic [31:0] rdWord);
      logic [15:0] cmd;
      logic r;
      cmd = {rd, adr};
      rdWord = 32'h0;
      spiCsN = 1'b0;
      wt(HALF);
      for (int i = 15; i >= 0; i--) bitx(cmd[i], r);
      for (int i = 0; i < 8 * n; i++)
      begin
         bitx(wr[31 - i], r);
         rdWord = {rdWord[30:0], r};
      end
      wt(HALF);
      spiCsN = 1'b1;
      spiSdi = ~spiSdi; // Released line shows no stale value
      wt(24);
   endtask : frame
endmodule : scir_spi_host

// file: test/test_serial_config_id_regs.sv
// Self-checking bench for the setup and identification registers
`timescale 1ns/10ps
module test_serial_config_id_regs;
   logic sys_clk;
   logic reset_n;
   logic spiCsN;
   logic spiSclk;
   logic spiSdi;
   logic spiSdo;
   logic chipResetN;
   logic [1:0] powerState;
   logic powerDown;
   logic [31:0] got;
   int err_count = 0;
   int checks_done = 0;
   // Identity codes are arbitrary values
   serial_config_id_regs #(.CLASS_CODE(4'h9), .FAMILY_CODE(16'h1e2d)) dut (.sys_clk(sys_clk),
      .reset_n(reset_n), .spiCsN(spiCsN), .spiSclk(spiSclk), .spiSdi(spiSdi), .spiSdo(spiSdo),
      .chipResetN(chipResetN), .powerState(powerState), .powerDown(powerDown));
   scir_spi_host host (.sys_clk(sys_clk), .spiCsN(spiCsN), .spiSclk(spiSclk),
      .spiSdi(spiSdi), .spiSdo(spiSdo));
   // 25 MHz clock
   initial
   begin
      sys_clk = 1'b0;
      forever #20 sys_clk = ~sys_clk;
   end
   // Compare and count
   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp)
      begin
         err_count++;
         $display("[ERR] %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk
   task automatic rd(input logic [14:0] a, input int n, input logic [31:0] exp, input string w);
      host.frame(1'b1, a, 32'h0, n, got);
      chk(w, got, exp);
   endtask : rd
   task automatic wr(input logic [14:0] a, input int n, input logic [31:0] d);
      host.frame(1'b0, a, d, n, got);
   endtask : wr
   task automatic wrap_up;
      $display("checks %0d mismatches %0d", checks_done, err_count);
      if (err_count == 0 && checks_done > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : wrap_up
   // -----------------------------------------------------------------
   // Test sequence
   // -----------------------------------------------------------------
   initial
   begin
      reset_n = 1'b0;
      repeat (16) @(posedge sys_clk);
      #1 reset_n = 1'b1;
      host.wt(8);
      rd(15'h0000, 1, 32'h30, "setup");
      rd(15'h0002, 1, 32'h00, "power");
      rd(15'h0003, 1, 32'h09, "class");
      rd(15'h0004, 2, 32'h2d1e, "family up");
      $display("test reset values done");
      wr(15'h0003, 1, 32'hff000000);
      rd(15'h0003, 1, 32'hf9, "class ro");
      wr(15'h0004, 2, 32'h00000000);
      rd(15'h0004, 2, 32'h2d1e, "family ro");
      wr(15'h0000, 1, 32'h20000000);
      rd(15'h0000, 1, 32'h30, "flag ro");
      $display("test fixed fields done");
      for (int v = 0; v < 4; v++)
      begin
         wr(15'h0002, 1, {v[7:0], 24'h0});
         chk("state", {30'h0, powerState}, v);
         chk("down", {31'h0, powerDown}, {31'h0, v == 3});
      end
      $display("test power codes done");
      wr(15'h0000, 1, 32'h00000000);
      rd(15'h0000, 1, 32'h10, "setup down");
      wr(15'h0003, 2, 32'h50020000); // Class then power, counting down
      rd(15'h0002, 1, 32'h02, "step down");
      rd(15'h0003, 1, 32'h59, "class down");
      rd(15'h0005, 2, 32'h1e2d, "family down");
      wr(15'h0010, 1, 32'h01000000);
      rd(15'h0004, 2, 32'h2d2d, "frozen");
      rd(15'h0007, 1, 32'h00, "unmapped");
      $display("test streaming done");
      wr(15'h0000, 1, 32'h80000000);
      rd(15'h0000, 1, 32'h30, "after soft reset");
      rd(15'h0004, 2, 32'h2d1e, "freeze cleared");
      rd(15'h0003, 1, 32'h09, "class cleared");
      chk("state cleared", {30'h0, powerState}, 32'h0);
      chk("down cleared", {31'h0, powerDown}, 32'h0);
      chk("chip reset released", {31'h0, chipResetN}, 32'h1);
      $display("test soft reset done");
      wrap_up();
   end
   // Hang guard, well beyond the expected run
   initial
   begin
      repeat (60000) @(posedge sys_clk);
      err_count++;
      wrap_up();
   end
endmodule : test_serial_config_id_regs
bind serial_config_id_regs scir_regs_chk chk (.sys_clk(sys_clk), .reset_n(reset_n),
   .spiCsN(spiCsN), .spiSclk(spiSclk), .spiSdi(spiSdi), .spiSdo(spiSdo),
   .chipResetN(chipResetN), .powerState(powerState), .powerDown(powerDown));
